// file: design/wst_defines.svh
`ifndef WST_DEFINES_SVH
`define WST_DEFINES_SVH

`define WST_OFF_CTRL        8'h00
`define WST_OFF_TIMEOUT     8'h04
`define WST_OFF_WINDOW      8'h08
`define WST_OFF_WARN        8'h0c
`define WST_OFF_FEED        8'h10
`define WST_OFF_STATUS      8'h14
`define WST_OFF_COUNT       8'h18

`define WST_CTRL_ENABLE_BIT  0
`define WST_CTRL_RESET_BIT   1
`define WST_CTRL_WINDOW_BIT  2
`define WST_CTRL_WARN_BIT    3

`define WST_STAT_TOUT_BIT    0
`define WST_STAT_WARN_BIT    1
`define WST_STAT_EVENT_BIT   2

`define WST_TIMEOUT_RST      24'hffffff
`define WST_WINDOW_RST       24'hffffff
`define WST_WARN_RST         24'h000000
`define WST_TIMEOUT_MIN      24'h000100
`define WST_PRESCALE_DIV     4

`define WST_FEED_KEY_FIRST   8'haa
`define WST_FEED_KEY_SECOND  8'h55

`define WST_RESP_OKAY        2'h0
`define WST_RESP_SLVERR      2'h2

`endif

// file: design/wst_pkg.sv
package wst_pkg;

  typedef struct packed {
    logic warn_en;
    logic window_sel;
    logic reset_sel;
    logic enable;
  } wst_ctrl_type;

  typedef enum logic [0:0] {
    WST_FEED_IDLE  = 1'b0,
    WST_FEED_ARMED = 1'b1
  } wst_feed_type;

endpackage

// file: design/wst_tick_prescaler.sv
`timescale 1ns/1ps
`default_nettype none
`include "wst_defines.svh"

module wst_tick_prescaler
  import wst_pkg::*;
#(
  parameter int DIV = `WST_PRESCALE_DIV
)
(
  input  wire logic aclk,
  input  wire logic aresetn,
  input  wire logic ce,
  input  wire logic watchdog_tick_clock,
  input  wire logic run,
  output logic      tick
);

  localparam int CW = (DIV > 1) ? $clog2(DIV) : 1;

  logic          meta_reg;
  logic          sync_reg;
  logic          prev_reg;
  logic [CW-1:0] div_reg;
  logic [CW-1:0] div_next;
  logic          tick_reg;
  logic          tick_next;

  ////////////////////////////////////////////////////////////////////////////
  // Edge of the oscillator, divided down
  always_comb
  begin
    div_next  = div_reg;
    tick_next = 1'b0;
    if (!run)
    begin
      div_next = '0;
    end
    else if (sync_reg && !prev_reg)
    begin
      if (div_reg == CW'(DIV - 1))
      begin
        div_next  = '0;
        tick_next = 1'b1;
      end
      else
      begin
        div_next = div_reg + CW'(1);
      end
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      meta_reg <= 1'b0;
      sync_reg <= 1'b0;
      prev_reg <= 1'b0;
      div_reg  <= '0;
      tick_reg <= 1'b0;
    end
    else if (ce)
    begin
      meta_reg <= watchdog_tick_clock;
      sync_reg <= meta_reg;
      prev_reg <= sync_reg;
      div_reg  <= div_next;
      tick_reg <= tick_next;
    end
  end

  assign tick = tick_reg;

endmodule
`default_nettype wire

// file: design/wst_windowed_service_timer.sv
// Design decisions made here: the register addresses and register access over AXI4-Lite.
`timescale 1ns/1ps
`default_nettype none
`include "wst_defines.svh"

module wst_windowed_service_timer
  import wst_pkg::*;
#(
  parameter int CW  = 24,
  parameter int DIV = `WST_PRESCALE_DIV
)
(
  input  wire logic          aclk,
  input  wire logic          aresetn,
  input  wire logic          por_resetn,
  input  wire logic          ce,
  input  wire logic          watchdog_tick_clock,
  input  wire logic [7:0]    s_axi_awaddr,
  input  wire logic          s_axi_awvalid,
  output logic               s_axi_awready,
  input  wire logic [31:0]   s_axi_wdata,
  input  wire logic [3:0]    s_axi_wstrb,
  input  wire logic          s_axi_wvalid,
  output logic               s_axi_wready,
  output logic [1:0]         s_axi_bresp,
  output logic               s_axi_bvalid,
  input  wire logic          s_axi_bready,
  input  wire logic [7:0]    s_axi_araddr,
  input  wire logic          s_axi_arvalid,
  output logic               s_axi_arready,
  output logic [31:0]        s_axi_rdata,
  output logic [1:0]         s_axi_rresp,
  output logic               s_axi_rvalid,
  input  wire logic          s_axi_rready,
  output logic               chip_reset_req,
  output logic               wd_irq
);

  logic          tick;

  logic          aw_full_reg;
  logic          aw_full_next;
  logic [7:0]    awaddr_reg;
  logic [7:0]    awaddr_next;
  logic          w_full_reg;
  logic          w_full_next;
  logic [31:0]   wdata_reg;
  logic [31:0]   wdata_next;
  logic [3:0]    wstrb_reg;
  logic [3:0]    wstrb_next;
  logic          bvalid_reg;
  logic          bvalid_next;
  logic [1:0]    bresp_reg;
  logic [1:0]    bresp_next;
  logic          rvalid_reg;
  logic          rvalid_next;
  logic [31:0]   rdata_reg;
  logic [31:0]   rdata_next;
  logic [1:0]    rresp_reg;
  logic [1:0]    rresp_next;
  logic          wr_fire;

  wst_ctrl_type  ctrl_reg;
  wst_ctrl_type  ctrl_next;
  logic [CW-1:0] timeout_reg;
  logic [CW-1:0] timeout_next;
  logic [CW-1:0] window_reg;
  logic [CW-1:0] window_next;
  logic [CW-1:0] warn_reg;
  logic [CW-1:0] warn_next;
  logic [CW-1:0] count_reg;
  logic [CW-1:0] count_next;
  wst_feed_type  feed_reg;
  wst_feed_type  feed_next;
  logic          warn_flag_reg;
  logic          warn_flag_next;
  logic          event_flag_reg;
  logic          event_flag_next;
  logic          reset_req_reg;
  logic          reset_req_next;
  logic          irq_reg;
  logic          irq_next;
  logic          tout_flag_reg;
  logic          tout_flag_next;

  logic [31:0]   wval;
  logic          feed_ok;
  logic          feed_bad;
  logic          early;
  logic          reload;
  logic          fault;
  logic          timeout_evt;
  logic          warn_evt;
  logic          wd_evt;

  function automatic logic [31:0] wst_merge(input logic [31:0] old_val,
                                            input logic [31:0] new_val,
                                            input logic [3:0]  strb);
    logic [31:0] res;
    res = old_val;
    for (int i = 0; i < 4; i++)
    begin
      if (strb[i])
      begin
        res[i*8 +: 8] = new_val[i*8 +: 8];
      end
    end
    return res;
  endfunction

  function automatic logic wst_mapped(input logic [7:0] addr);
    return (addr == `WST_OFF_CTRL) || (addr == `WST_OFF_TIMEOUT) ||
           (addr == `WST_OFF_WINDOW) || (addr == `WST_OFF_WARN) ||
           (addr == `WST_OFF_FEED) || (addr == `WST_OFF_STATUS) ||
           (addr == `WST_OFF_COUNT);
  endfunction

  wst_tick_prescaler #(
    .DIV (DIV)
  ) u_prescaler (
    .aclk                (aclk),
    .aresetn             (aresetn),
    .ce                  (ce),
    .watchdog_tick_clock (watchdog_tick_clock),
    .run                 (ctrl_reg.enable),
    .tick                (tick)
  );

  ////////////////////////////////////////////////////////////////////////////
  // AXI4-Lite slave; address and data are taken in either order
  assign s_axi_awready = ce && !aw_full_reg;
  assign s_axi_wready  = ce && !w_full_reg;
  assign s_axi_arready = ce && !rvalid_reg;
  assign wr_fire       = aw_full_reg && w_full_reg && !bvalid_reg;

  always_comb
  begin
    aw_full_next = aw_full_reg;
    awaddr_next  = awaddr_reg;
    w_full_next  = w_full_reg;
    wdata_next   = wdata_reg;
    wstrb_next   = wstrb_reg;
    bvalid_next  = bvalid_reg;
    bresp_next   = bresp_reg;
    rvalid_next  = rvalid_reg;
    rdata_next   = rdata_reg;
    rresp_next   = rresp_reg;
    if (s_axi_awvalid && !aw_full_reg)
    begin
      aw_full_next = 1'b1;
      awaddr_next  = {s_axi_awaddr[7:2], 2'b00};
    end
    if (s_axi_wvalid && !w_full_reg)
    begin
      w_full_next = 1'b1;
      wdata_next  = s_axi_wdata;
      wstrb_next  = s_axi_wstrb;
    end
    if (bvalid_reg && s_axi_bready)
    begin
      bvalid_next = 1'b0;
    end
    if (wr_fire)
    begin
      aw_full_next = 1'b0;
      w_full_next  = 1'b0;
      bvalid_next  = 1'b1;
      bresp_next   = wst_mapped(awaddr_reg) ? `WST_RESP_OKAY : `WST_RESP_SLVERR;
    end
    if (rvalid_reg && s_axi_rready)
    begin
      rvalid_next = 1'b0;
    end
    if (s_axi_arvalid && !rvalid_reg)
    begin
      rvalid_next = 1'b1;
      rresp_next  = `WST_RESP_OKAY;
      case ({s_axi_araddr[7:2], 2'b00})
        `WST_OFF_CTRL:    rdata_next = {28'h0000000, ctrl_reg};
        `WST_OFF_TIMEOUT: rdata_next = 32'(timeout_reg);
        `WST_OFF_WINDOW:  rdata_next = 32'(window_reg);
        `WST_OFF_WARN:    rdata_next = 32'(warn_reg);
        `WST_OFF_STATUS:  rdata_next = {29'h0000000, event_flag_reg, warn_flag_reg,
                                        tout_flag_reg};
        `WST_OFF_COUNT:   rdata_next = 32'(count_reg);
        `WST_OFF_FEED:    rdata_next = 32'h00000000;
        default:
        begin
          rdata_next = 32'h00000000;
          rresp_next = `WST_RESP_SLVERR;
        end
      endcase
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_full_reg <= 1'b0;
      awaddr_reg  <= 8'h00;
      w_full_reg  <= 1'b0;
      wdata_reg   <= 32'h00000000;
      wstrb_reg   <= 4'h0;
      bvalid_reg  <= 1'b0;
      bresp_reg   <= `WST_RESP_OKAY;
      rvalid_reg  <= 1'b0;
      rdata_reg   <= 32'h00000000;
      rresp_reg   <= `WST_RESP_OKAY;
    end
    else if (ce)
    begin
      aw_full_reg <= aw_full_next;
      awaddr_reg  <= awaddr_next;
      w_full_reg  <= w_full_next;
      wdata_reg   <= wdata_next;
      wstrb_reg   <= wstrb_next;
      bvalid_reg  <= bvalid_next;
      bresp_reg   <= bresp_next;
      rvalid_reg  <= rvalid_next;
      rdata_reg   <= rdata_next;
      rresp_reg   <= rresp_next;
    end
  end

  assign s_axi_bvalid = bvalid_reg;
  assign s_axi_bresp  = bresp_reg;
  assign s_axi_rvalid = rvalid_reg;
  assign s_axi_rdata  = rdata_reg;
  assign s_axi_rresp  = rresp_reg;

  ////////////////////////////////////////////////////////////////////////////
  // Watchdog core
  always_comb
  begin
    ctrl_next       = ctrl_reg;
    timeout_next    = timeout_reg;
    window_next     = window_reg;
    warn_next       = warn_reg;
    count_next      = count_reg;
    feed_next       = feed_reg;
    warn_flag_next  = warn_flag_reg;
    event_flag_next = event_flag_reg;
    reset_req_next  = reset_req_reg;
    tout_flag_next  = tout_flag_reg;
    wval            = 32'h00000000;
    feed_ok         = 1'b0;
    feed_bad        = 1'b0;
    if (wr_fire)
    begin
      // Any other write between the two keys breaks the sequence
      if (feed_reg == WST_FEED_ARMED && awaddr_reg != `WST_OFF_FEED)
      begin
        feed_bad  = 1'b1;
        feed_next = WST_FEED_IDLE;
      end
      case (awaddr_reg)
        `WST_OFF_CTRL:
        begin
          wval = wst_merge({28'h0000000, ctrl_reg}, wdata_reg, wstrb_reg);
          ctrl_next.enable     = ctrl_reg.enable | wval[`WST_CTRL_ENABLE_BIT];
          // Reset response cannot be dropped once running
          ctrl_next.reset_sel  = wval[`WST_CTRL_RESET_BIT] |
                                 (ctrl_reg.enable & ctrl_reg.reset_sel);
          ctrl_next.window_sel = wval[`WST_CTRL_WINDOW_BIT];
          ctrl_next.warn_en    = wval[`WST_CTRL_WARN_BIT];
          if (!ctrl_reg.enable && wval[`WST_CTRL_ENABLE_BIT])
          begin
            count_next = timeout_reg;
          end
        end
        `WST_OFF_TIMEOUT:
        begin
          wval = wst_merge(32'(timeout_reg), wdata_reg, wstrb_reg);
          // Shortest legal period is 256 prescaled ticks
          timeout_next = (wval[CW-1:0] < CW'(`WST_TIMEOUT_MIN)) ?
                         CW'(`WST_TIMEOUT_MIN) : wval[CW-1:0];
        end
        `WST_OFF_WINDOW:
        begin
          wval        = wst_merge(32'(window_reg), wdata_reg, wstrb_reg);
          window_next = wval[CW-1:0];
        end
        `WST_OFF_WARN:
        begin
          wval      = wst_merge(32'(warn_reg), wdata_reg, wstrb_reg);
          warn_next = wval[CW-1:0];
        end
        `WST_OFF_FEED:
        begin
          if (wstrb_reg[0])
          begin
            if (feed_reg == WST_FEED_IDLE)
            begin
              if (wdata_reg[7:0] == `WST_FEED_KEY_FIRST)
              begin
                feed_next = WST_FEED_ARMED;
              end
              else
              begin
                feed_bad = 1'b1;
              end
            end
            else
            begin
              feed_next = WST_FEED_IDLE;
              if (wdata_reg[7:0] == `WST_FEED_KEY_SECOND)
              begin
                feed_ok = 1'b1;
              end
              else
              begin
                feed_bad = 1'b1;
              end
            end
          end
        end
        `WST_OFF_STATUS:
        begin
          if (wstrb_reg[0])
          begin
            tout_flag_next  = tout_flag_reg & ~wdata_reg[`WST_STAT_TOUT_BIT];
            warn_flag_next  = warn_flag_reg & ~wdata_reg[`WST_STAT_WARN_BIT];
            event_flag_next = event_flag_reg & ~wdata_reg[`WST_STAT_EVENT_BIT];
          end
        end
        default:
        begin
        end
      endcase
    end

    early       = ctrl_reg.window_sel && (count_reg > window_reg);
    reload      = feed_ok && !early;
    fault       = ctrl_reg.enable && (feed_bad || (feed_ok && early));
    timeout_evt = ctrl_reg.enable && tick && !reload && (count_reg == CW'(1));
    warn_evt    = ctrl_reg.enable && tick && !reload && ctrl_reg.warn_en &&
                  ((count_reg - CW'(1)) == warn_reg);
    wd_evt      = timeout_evt || fault;

    if (reload)
    begin
      count_next = timeout_reg;
    end
    else if (ctrl_reg.enable && tick)
    begin
      count_next = (count_reg == CW'(1)) ? timeout_reg : count_reg - CW'(1);
    end

    // Hardware sets win over a software clear in the same cycle
    if (warn_evt)
    begin
      warn_flag_next = 1'b1;
    end
    if (wd_evt)
    begin
      ctrl_next.enable = 1'b0;
      if (ctrl_reg.reset_sel)
      begin
        reset_req_next = 1'b1;
        tout_flag_next = 1'b1;
      end
      else
      begin
        event_flag_next = 1'b1;
      end
    end
    if (timeout_evt)
    begin
      tout_flag_next = 1'b1;
    end
    irq_next = event_flag_next || (warn_flag_next && ctrl_next.warn_en);
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      ctrl_reg       <= '0;
      timeout_reg    <= CW'(`WST_TIMEOUT_RST);
      window_reg     <= CW'(`WST_WINDOW_RST);
      warn_reg       <= CW'(`WST_WARN_RST);
      count_reg      <= CW'(`WST_TIMEOUT_RST);
      feed_reg       <= WST_FEED_IDLE;
      warn_flag_reg  <= 1'b0;
      event_flag_reg <= 1'b0;
      reset_req_reg  <= 1'b0;
      irq_reg        <= 1'b0;
    end
    else if (ce)
    begin
      ctrl_reg       <= ctrl_next;
      timeout_reg    <= timeout_next;
      window_reg     <= window_next;
      warn_reg       <= warn_next;
      count_reg      <= count_next;
      feed_reg       <= feed_next;
      warn_flag_reg  <= warn_flag_next;
      event_flag_reg <= event_flag_next;
      reset_req_reg  <= reset_req_next;
      irq_reg        <= irq_next;
    end
  end

  // Survives the chip reset it causes; only power-on or a STATUS write clears it
  always_ff @(posedge aclk)
  begin
    if (!por_resetn)
    begin
      tout_flag_reg <= 1'b0;
    end
    else if (ce)
    begin
      tout_flag_reg <= tout_flag_next;
    end
  end

  assign chip_reset_req = reset_req_reg;
  assign wd_irq         = irq_reg;

endmodule
`default_nettype wire

// file: verification/wst_checker_properties.sv
`timescale 1ns/1ps
`default_nettype none

module wst_checker
  import wst_pkg::*;
#(
  parameter int CW  = 24,
  parameter int DIV = 4
)
(
  input wire logic       aclk,
  input wire logic       aresetn,
  input wire logic       s_axi_awvalid,
  input wire logic       s_axi_awready,
  input wire logic       s_axi_wvalid,
  input wire logic       s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic       s_axi_bvalid,
  input wire logic       s_axi_arvalid,
  input wire logic       s_axi_arready,
  input wire logic [1:0] s_axi_rresp,
  input wire logic       s_axi_rvalid,
  input wire logic       chip_reset_req,
  input wire logic       wd_irq
);
  default clocking cb @(posedge aclk);
  endclocking

  chk_reset_holds: assert property (chip_reset_req && aresetn |=> chip_reset_req)
    else $error("chip reset request dropped without reset");
  chk_req_falls: assert property ($fell(chip_reset_req) |-> $past(!aresetn))
    else $error("chip reset request fell outside reset");
  // A clearing write drops the flags at the edge that raises bvalid
  chk_irq_falls: assert property ($fell(wd_irq) |-> $past(!aresetn) || s_axi_bvalid)
    else $error("interrupt fell without reset or write");
  chk_outputs_idle: assert property (!aresetn |=> !chip_reset_req && !wd_irq && !s_axi_bvalid)
    else $error("outputs not idle after reset");
  chk_b_after_both: assert property (disable iff (!aresetn)
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready && !s_axi_bvalid
    |-> ##2 s_axi_bvalid)
    else $error("write response late");
  chk_r_after_ar: assert property (disable iff (!aresetn)
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read data late");
  chk_ar_refused: assert property (disable iff (!aresetn) s_axi_rvalid |-> !s_axi_arready)
    else $error("read address taken while data pending");
  chk_resp_legal: assert property (disable iff (!aresetn)
    s_axi_bvalid || s_axi_rvalid |-> s_axi_bresp != 2'h1 && s_axi_rresp != 2'h1)
    else $error("illegal response code");

  cov_reset: cover property ($rose(chip_reset_req));
  cov_irq: cover property ($rose(wd_irq));
  cov_slverr: cover property (s_axi_rvalid && s_axi_rresp == 2'h2);
endmodule

bind wst_windowed_service_timer wst_checker #(.CW(CW), .DIV(DIV)) chk_u (
  .aclk(aclk), .aresetn(aresetn), .s_axi_awvalid(s_axi_awvalid),
  .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
  .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_arvalid(s_axi_arvalid),
  .s_axi_arready(s_axi_arready), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
  .chip_reset_req(chip_reset_req), .wd_irq(wd_irq));

`default_nettype wire

// file: verification/tb.sv
`timescale 1ns/1ps
`default_nettype none
`include "wst_defines.svh"

module tb;
  import wst_pkg::*;
  logic        aclk = 1'b0;
  logic        aresetn = 1'b0;
  logic        por_n = 1'b0;
  logic        tclk = 1'b0;
  logic [7:0]  aw_a = 8'h00;
  logic        aw_v = 1'b0;
  logic [31:0] w_d = 32'h0;
  logic        w_v = 1'b0;
  logic        b_r = 1'b0;
  logic [7:0]  ar_a = 8'h00;
  logic        ar_v = 1'b0;
  logic        r_r = 1'b0;
  wire logic   awready, wready, bvalid, arready, rvalid, rst_req, irq;
  wire logic [1:0]  bresp, rresp;
  wire logic [31:0] rdata;
  int          fail_count = 0;
  int          checked = 0;
  logic [31:0] v;
  logic [1:0]  resp;
  logic        hit;

  wst_windowed_service_timer dut_u (
    .aclk(aclk), .aresetn(aresetn), .por_resetn(por_n), .ce(1'b1), .watchdog_tick_clock(tclk),
    .s_axi_awaddr(aw_a), .s_axi_awvalid(aw_v), .s_axi_awready(awready), .s_axi_wdata(w_d),
    .s_axi_wstrb(4'hf), .s_axi_wvalid(w_v), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(b_r), .s_axi_araddr(ar_a), .s_axi_arvalid(ar_v),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(r_r), .chip_reset_req(rst_req), .wd_irq(irq));

  initial
  begin
    forever #5 aclk = ~aclk;
  end

  ////////////////////////////////////////////////////////////////////////////////
  task conclude;
    $display("errors %0d checks %0d", fail_count, checked);
    if (fail_count == 0 && checked > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  task chk(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("mismatch at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  // Both channels offered together, each dropped once taken
  task wr(input logic [7:0] a, input logic [31:0] d);
    logic ah, wh, bh;
    @(posedge aclk);
    aw_a <= a; aw_v <= 1'b1; w_d <= d; w_v <= 1'b1; b_r <= 1'b1;
    bh = 1'b0;
    for (int n = 0; !bh; n++)
    begin
      #1;
      ah = aw_v & awready;
      wh = w_v & wready;
      bh = bvalid;
      resp = bresp;
      if (n > 50)
      begin
        chk(32'h0, 32'h1);
        conclude();
      end
      @(posedge aclk);
      if (ah) aw_v <= 1'b0;
      if (wh) w_v <= 1'b0;
    end
    b_r <= 1'b0;
  endtask

  task rd(input logic [7:0] a);
    logic ah, rh;
    @(posedge aclk);
    ar_a <= a; ar_v <= 1'b1; r_r <= 1'b1;
    rh = 1'b0;
    for (int n = 0; !rh; n++)
    begin
      #1;
      ah = ar_v & arready;
      rh = rvalid;
      v = rdata;
      resp = rresp;
      if (n > 50)
      begin
        chk(32'h0, 32'h1);
        conclude();
      end
      @(posedge aclk);
      if (ah) ar_v <= 1'b0;
    end
    r_r <= 1'b0;
  endtask

  // One tick clock rising edge every 4 cycles; which: 1 reset request, 2 interrupt
  task ticks(input int n, input int which);
    hit = 1'b0;
    repeat (n + 1)
    begin
      @(posedge aclk) tclk <= (n > 0);
      @(posedge aclk);
      @(posedge aclk) tclk <= 1'b0;
      @(posedge aclk);
      #1;
      if ((which == 1 && rst_req === 1'b1) || (which == 2 && irq === 1'b1)) hit = 1'b1;
      n--;
    end
  endtask

  task do_reset;
    @(posedge aclk) aresetn <= 1'b0;
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
  endtask

  task feed(input logic [31:0] second);
    wr(`WST_OFF_FEED, 32'haa);
    wr(`WST_OFF_FEED, second);
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  task s_reset_values;
    rd(`WST_OFF_TIMEOUT); chk(v, 32'h00ffffff);
    rd(`WST_OFF_COUNT); chk(v, 32'h00ffffff);
    rd(8'h1c); chk({30'h0, resp}, 32'h2);
    wr(8'h1c, 32'h1); chk({30'h0, resp}, 32'h2);
  endtask

  task s_timeout;
    wr(`WST_OFF_TIMEOUT, 32'h10); rd(`WST_OFF_TIMEOUT); chk(v, 32'h100);
    wr(`WST_OFF_CTRL, 32'h3);
    ticks(1016, 1); chk({31'h0, hit}, 32'h0);
    ticks(16, 1); chk({31'h0, hit}, 32'h1);
    rd(`WST_OFF_CTRL); chk({31'h0, v[0]}, 32'h0);
    do_reset();
    chk({31'h0, rst_req}, 32'h0);
    rd(`WST_OFF_STATUS); chk({31'h0, v[0]}, 32'h1);
    wr(`WST_OFF_STATUS, 32'h1); rd(`WST_OFF_STATUS); chk({31'h0, v[0]}, 32'h0);
  endtask

  task s_feed;
    wr(`WST_OFF_TIMEOUT, 32'h100);
    wr(`WST_OFF_CTRL, 32'h1);
    wr(`WST_OFF_CTRL, 32'h0); rd(`WST_OFF_CTRL); chk({31'h0, v[0]}, 32'h1);
    ticks(64, 0); rd(`WST_OFF_COUNT); chk(v, 32'hf0);
    // Tick clock held still: the count must not move
    repeat (100) @(posedge aclk);
    rd(`WST_OFF_COUNT); chk(v, 32'hf0);
    feed(32'h55); rd(`WST_OFF_COUNT); chk(v, 32'h100);
    feed(32'h33); ticks(0, 2); chk({31'h0, hit}, 32'h1);
    chk({31'h0, rst_req}, 32'h0);
    rd(`WST_OFF_CTRL); chk({31'h0, v[0]}, 32'h0);
    rd(`WST_OFF_STATUS); chk({31'h0, v[2]}, 32'h1);
    do_reset();
  endtask

  task s_window;
    for (int i = 0; i < 2; i++)
    begin
      wr(`WST_OFF_TIMEOUT, 32'h100);
      wr(`WST_OFF_WINDOW, 32'h80);
      wr(`WST_OFF_CTRL, 32'h5);
      // First pass feeds too early, second pass inside the window
      if (i == 1) ticks(576, 0);
      feed(32'h55);
      ticks(0, 2); chk({31'h0, hit}, {31'h0, i == 0});
      rd(`WST_OFF_COUNT); if (i == 1) chk(v, 32'h100);
      do_reset();
    end
  endtask

  task s_warn;
    wr(`WST_OFF_TIMEOUT, 32'h100);
    wr(`WST_OFF_WARN, 32'hf0);
    wr(`WST_OFF_CTRL, 32'h9);
    ticks(60, 2); chk({31'h0, hit}, 32'h0);
    ticks(8, 2); chk({31'h0, hit}, 32'h1);
    rd(`WST_OFF_STATUS); chk({31'h0, v[1]}, 32'h1);
    do_reset();
  endtask

  initial
  begin
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    por_n <= 1'b1;
    s_reset_values();
    s_timeout();
    s_feed();
    s_window();
    s_warn();
    conclude();
  end
endmodule

`default_nettype wire
